// >>> tbs_pkg.sv
// constants of the trace buffer status register bank
// assumes a 12-bit byte address bus with one 32-bit word per register
//
// Operation
// RL1 - a 32-bit read-only register returns the trace RAM depth counted in words.
// RL2 - status bit 3 reads 1 while the formatter pipeline is empty and all data is in RAM, else 0.
// RL3 - status bit 2 reads 1 once the formatter has stopped by any configured method or capture is disabled, else 0.
// RL4 - completing an acquisition also sets the formatter halted flag in the formatter status register.
// RL5 - status bit 1 is set when a trigger is observed under the current formatter control setup, else reads 0.
// RL6 - the triggered bit reflects only trigger observation, never whether a trigger marker went into the data.
// RL7 - status bit 0 reads 1 once the RAM write pointer has wrapped and 0 while it has not.
// RL8 - eight fixed read-only identification words sit at 0xfe0 through 0xffc, four peripheral then four component.
// RL9 - capture is active exactly while the halted flag is 0 and capture enable is 1; the read pointer is not written then.
// RL10 - status bits 31 to 4 read zero and reading the status register has no side effects.
package tbs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [11:0] OFF_RAM_DEPTH = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h018;
  localparam logic [11:0] OFF_CAPTURE_CTRL = 12'h020;
  localparam logic [11:0] OFF_FMT_STATUS = 12'h300;
  localparam logic [11:0] OFF_FMT_CTRL = 12'h304;
  localparam logic [11:0] OFF_PERIPH_ID0 = 12'hfe0;
  localparam logic [11:0] OFF_PERIPH_ID1 = 12'hfe4;
  localparam logic [11:0] OFF_PERIPH_ID2 = 12'hfe8;
  localparam logic [11:0] OFF_PERIPH_ID3 = 12'hfec;
  localparam logic [11:0] OFF_COMP_ID0 = 12'hff0;
  localparam logic [11:0] OFF_COMP_ID1 = 12'hff4;
  localparam logic [11:0] OFF_COMP_ID2 = 12'hff8;
  localparam logic [11:0] OFF_COMP_ID3 = 12'hffc;

  ////////////////////////////////////////////////////////////////////////////
  // buffer_status fields
  localparam int unsigned STS_FULL = 0;
  localparam int unsigned STS_TRIGGERED = 1;
  localparam int unsigned STS_DONE = 2;
  localparam int unsigned STS_DRAINED = 3;
  localparam int unsigned STS_W = 4;

  // irq fields: same layout in status, enable and clear
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_TRIG = 1;
  localparam int unsigned IRQ_FULL = 2;
  localparam int unsigned IRQ_W = 3;

  // capture_control_reg and formatter_status_reg fields
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned FSR_HALTED = 0;

  // formatter_control_reg fields
  localparam int unsigned FCR_TRIG_OBSERVE = 0;
  localparam int unsigned FCR_STOP_ON_TRIG = 1;
  localparam int unsigned FCR_STOP_NOW = 2;
  localparam int unsigned FCR_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and defaults
  localparam logic [31:0] RAM_DEPTH_DEFAULT = 32'h0000_0400;
  localparam logic [FCR_W-1:0] FCR_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
endpackage : tbs_pkg

// >>> tbs_wrap_detect.sv
// RAM write pointer wrap detector of the trace buffer status bank
// assumes the pointer comes from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module tbs_wrap_detect #(
  parameter int unsigned PTR_W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pointer side
  input wire logic capture_active,
  input wire logic [PTR_W-1:0] wr_ptr,
  // result
  output logic wrap_pulse
);
  logic [PTR_W-1:0] prev_ptr_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ptr_reg <= '0;
    end else begin
      prev_ptr_reg <= wr_ptr;
    end
  end

  // a pointer that steps backwards while capturing has rolled over the top
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_pulse <= 1'b0;
    end else begin
      wrap_pulse <= capture_active && (wr_ptr < prev_ptr_reg); // RL7
    end
  end
endmodule // tbs_wrap_detect
`default_nettype wire

// >>> tbs_status_regs.sv
// status and identification register bank of the trace buffer
// assumes formatter, trigger and write pointer inputs come from logic on clk
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module tbs_status_regs
  import tbs_pkg::*;
#(
  parameter logic [31:0] RAM_DEPTH = RAM_DEPTH_DEFAULT,
  parameter int unsigned PTR_W = 10,
  // identification words: values are arbitrary
  parameter logic [31:0] PERIPH_ID0 = 32'h0000_00a1,
  parameter logic [31:0] PERIPH_ID1 = 32'h0000_00a2,
  parameter logic [31:0] PERIPH_ID2 = 32'h0000_00a3,
  parameter logic [31:0] PERIPH_ID3 = 32'h0000_00a4,
  parameter logic [31:0] COMP_ID0 = 32'h0000_00c1,
  parameter logic [31:0] COMP_ID1 = 32'h0000_00c2,
  parameter logic [31:0] COMP_ID2 = 32'h0000_00c3,
  parameter logic [31:0] COMP_ID3 = 32'h0000_00c4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // formatter side
  input wire logic fmt_pipe_empty,
  input wire logic fmt_stop_evt,
  input wire logic trig_in,
  input wire logic [PTR_W-1:0] ram_wr_ptr,
  // control out
  output logic capture_enable_bit,
  output logic formatter_halted_flag,
  output logic capture_active,
  output logic [FCR_W-1:0] fmt_ctrl,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic wr_ctl, wr_fcr, wr_irq_en, wr_irq_clr;
  logic start_evt, stop_now, trig_seen, stop_any, wrap_pulse;
  logic capture_done;
  logic triggered_reg, full_reg, done_prev_reg;
  logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg, irq_evt;
  logic [STS_W-1:0] status_word;
  logic [DATA_W-1:0] rdata_next;

  // write strobe aimed at one offset; signals passed in so the assigns stay sensitive to them
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return wr && (addr == off);
  endfunction

  assign wr_ctl = wr_hit(reg_wr, reg_addr, OFF_CAPTURE_CTRL);
  assign wr_fcr = wr_hit(reg_wr, reg_addr, OFF_FMT_CTRL);
  assign wr_irq_en = wr_hit(reg_wr, reg_addr, OFF_IRQ_ENABLE);
  assign wr_irq_clr = wr_hit(reg_wr, reg_addr, OFF_IRQ_CLEAR);

  // capture restarts when enable goes from 0 to 1
  assign start_evt = wr_ctl && reg_wdata[CTL_ENABLE] && !capture_enable_bit;
  assign stop_now = wr_fcr && reg_wdata[FCR_STOP_NOW];

  ////////////////////////////////////////////////////////////////////////////
  // capture control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_enable_bit <= 1'b0;
    end else if (wr_ctl) begin
      capture_enable_bit <= reg_wdata[CTL_ENABLE];
    end
  end

  // stop_now is a request bit and never stays set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_ctrl <= FCR_RESET;
    end else if (wr_fcr) begin
      fmt_ctrl <= {1'b0, reg_wdata[FCR_STOP_ON_TRIG], reg_wdata[FCR_TRIG_OBSERVE]};
    end
  end

  assign capture_active = capture_enable_bit && !formatter_halted_flag; // RL9

  // trigger counts only when the formatter control asks it to be observed
  assign trig_seen = trig_in && fmt_ctrl[FCR_TRIG_OBSERVE] && capture_active; // RL5
  assign stop_any = fmt_stop_evt || stop_now || (trig_seen && fmt_ctrl[FCR_STOP_ON_TRIG]);

  ////////////////////////////////////////////////////////////////////////////
  // halted flag: a stop in the restart cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      formatter_halted_flag <= 1'b1;
    end else if (stop_any) begin
      formatter_halted_flag <= 1'b1; // RL4
    end else if (start_evt) begin
      formatter_halted_flag <= 1'b0;
    end else if (!capture_enable_bit) begin
      formatter_halted_flag <= 1'b1; // RL4
    end
  end

  assign capture_done = formatter_halted_flag || !capture_enable_bit; // RL3

  ////////////////////////////////////////////////////////////////////////////
  // sticky trigger and full flags, cleared by a capture restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      triggered_reg <= 1'b0;
    end else if (trig_seen) begin
      triggered_reg <= 1'b1; // RL5 RL6
    end else if (start_evt) begin
      triggered_reg <= 1'b0;
    end
  end

  tbs_wrap_detect #(
    .PTR_W(PTR_W)
  ) tbs_wrap_detect_inst (
    .clk(clk),
    .rst_b(rst_b),
    .capture_active(capture_active),
    .wr_ptr(ram_wr_ptr),
    .wrap_pulse(wrap_pulse)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      full_reg <= 1'b0;
    end else if (wrap_pulse) begin
      full_reg <= 1'b1; // RL7
    end else if (start_evt) begin
      full_reg <= 1'b0;
    end
  end

  assign status_word = {fmt_pipe_empty, capture_done, triggered_reg, full_reg}; // RL2 RL3 RL5 RL7

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_prev_reg <= 1'b1;
    end else begin
      done_prev_reg <= capture_done;
    end
  end

  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_DONE] = capture_done && !done_prev_reg;
    irq_evt[IRQ_TRIG] = trig_seen && !triggered_reg;
    irq_evt[IRQ_FULL] = wrap_pulse && !full_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_reg <= '0;
    end else if (wr_irq_clr) begin
      irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_status_reg <= irq_status_reg | irq_evt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_reg <= IRQ_EN_RESET;
    end else if (wr_irq_en) begin
      irq_enable_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read path: no register has a read side effect
  always_comb begin
    rdata_next = RDATA_UNMAPPED;
    case (reg_addr)
      OFF_RAM_DEPTH: rdata_next = RAM_DEPTH; // RL1
      OFF_STATUS: rdata_next = {{(DATA_W-STS_W){1'b0}}, status_word}; // RL10
      OFF_IRQ_STATUS: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_status_reg};
      OFF_IRQ_ENABLE: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_enable_reg};
      OFF_CAPTURE_CTRL: rdata_next = {{(DATA_W-1){1'b0}}, capture_enable_bit};
      OFF_FMT_STATUS: rdata_next = {{(DATA_W-1){1'b0}}, formatter_halted_flag};
      OFF_FMT_CTRL: rdata_next = {{(DATA_W-FCR_W){1'b0}}, fmt_ctrl};
      OFF_PERIPH_ID0: rdata_next = PERIPH_ID0; // RL8
      OFF_PERIPH_ID1: rdata_next = PERIPH_ID1; // RL8
      OFF_PERIPH_ID2: rdata_next = PERIPH_ID2; // RL8
      OFF_PERIPH_ID3: rdata_next = PERIPH_ID3; // RL8
      OFF_COMP_ID0: rdata_next = COMP_ID0; // RL8
      OFF_COMP_ID1: rdata_next = COMP_ID1; // RL8
      OFF_COMP_ID2: rdata_next = COMP_ID2; // RL8
      OFF_COMP_ID3: rdata_next = COMP_ID3; // RL8
      default: rdata_next = RDATA_UNMAPPED;
    endcase
  end

  // data is held for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_depth_read: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    reg_rd && reg_addr == OFF_RAM_DEPTH |=> reg_rdata == RAM_DEPTH)
    else $error("depth register read wrong value");

  a_drained_bit: assert property (@(posedge clk) disable iff (!rst_b) // RL2
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[STS_DRAINED] == $past(fmt_pipe_empty))
    else $error("drained bit does not follow pipeline empty");

  a_done_when_off: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    reg_rd && reg_addr == OFF_STATUS && !capture_enable_bit |=> reg_rdata[STS_DONE])
    else $error("capture done low while capture disabled");

  a_stop_halts: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    fmt_stop_evt |=> formatter_halted_flag ##1 (formatter_halted_flag || capture_enable_bit))
    else $error("stop event did not set halted flag");

  a_trig_sets: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    trig_in && fmt_ctrl[FCR_TRIG_OBSERVE] && capture_active |=> triggered_reg)
    else $error("observed trigger not recorded");

  a_trig_ignored: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    !triggered_reg && !(trig_in && fmt_ctrl[FCR_TRIG_OBSERVE]) |=> !triggered_reg)
    else $error("triggered bit set without observed trigger");

  a_full_sticky: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    wrap_pulse |=> full_reg [*2] or (full_reg ##1 $past(start_evt)))
    else $error("full flag not held after wrap");

  a_ident_word: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    reg_rd && reg_addr == OFF_COMP_ID3 |=> reg_rdata == COMP_ID3)
    else $error("identification word wrong");

  a_active_def: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    $rose(capture_active) |-> $past(start_evt) && capture_enable_bit)
    else $error("capture active without a restart");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    reg_rd && reg_addr == OFF_STATUS |=>
    reg_rdata[DATA_W-1:STS_W] == '0 && irq_status_reg == ($past(irq_status_reg) | $past(irq_evt)))
    else $error("status read nonzero reserved bits or side effect");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b) // RL10
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside read cycle");

  a_trig_status: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[STS_TRIGGERED] == $past(triggered_reg))
    else $error("triggered bit read wrong");

  a_full_status: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[STS_FULL] == $past(full_reg))
    else $error("full bit read wrong");

  a_done_status: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    reg_rd && reg_addr == OFF_STATUS |=>
    reg_rdata[STS_DONE] == ($past(formatter_halted_flag) || !$past(capture_enable_bit)))
    else $error("done bit read wrong");

  a_any_stop_halts: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    stop_any |=> formatter_halted_flag)
    else $error("stop did not halt formatter");

  a_off_halts: assert property (@(posedge clk) disable iff (!rst_b) // RL4
    !capture_enable_bit && !start_evt |=> formatter_halted_flag)
    else $error("halted flag low while capture disabled");

  a_start_clears: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    start_evt && !stop_any && !wrap_pulse |=> capture_active && !triggered_reg && !full_reg)
    else $error("restart did not activate capture or clear flags");

  a_enable_write: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    wr_ctl |=> capture_enable_bit == $past(reg_wdata[CTL_ENABLE]))
    else $error("capture enable not written");

  a_wrap_active: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    wrap_pulse |-> $past(capture_active))
    else $error("wrap seen while capture inactive");

  a_trig_stops: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    trig_seen && fmt_ctrl[FCR_STOP_ON_TRIG] |=> formatter_halted_flag && triggered_reg)
    else $error("stop on trigger did not halt");

  a_stop_req_clear: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    !fmt_ctrl[FCR_STOP_NOW])
    else $error("stop request bit stayed set");

  a_irq_set_wins: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    irq_evt[IRQ_FULL] |=> irq_status_reg[IRQ_FULL])
    else $error("full event not latched in interrupt status");

  a_irq_clears: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    wr_irq_clr && reg_wdata[IRQ_TRIG] && !irq_evt[IRQ_TRIG] |=> !irq_status_reg[IRQ_TRIG])
    else $error("interrupt status bit not cleared");

  a_periph_first: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    reg_rd && reg_addr == OFF_PERIPH_ID0 |=> reg_rdata == PERIPH_ID0)
    else $error("first identification word wrong");
endmodule // tbs_status_regs
`default_nettype wire

// >>> tb_tbs_status_regs.sv
// self-checking testbench of the trace buffer status register bank
// assumes tbs_pkg and tbs_status_regs are compiled first; one clock at 250 MHz
`timescale 1ns/1ns
`default_nettype none
module tb_tbs_status_regs
  import tbs_pkg::*;
;
  // identification words: values are arbitrary
  localparam logic [31:0] ID_VALS [8] = '{32'h0000_0011, 32'h0000_0012, 32'h0000_0013, 32'h0000_0014,
                                          32'h0000_0021, 32'h0000_0022, 32'h0000_0023, 32'h0000_0024};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic fmt_pipe_empty = 1'b1;
  logic fmt_stop_evt = 1'b0;
  logic trig_in = 1'b0;
  logic [9:0] ram_wr_ptr = '0;
  logic capture_enable_bit;
  logic formatter_halted_flag;
  logic capture_active;
  logic [FCR_W-1:0] fmt_ctrl;
  logic irq;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int i;

  always #2 clk = ~clk;

  tbs_status_regs #(
    .PERIPH_ID0(ID_VALS[0]), .PERIPH_ID1(ID_VALS[1]), .PERIPH_ID2(ID_VALS[2]), .PERIPH_ID3(ID_VALS[3]),
    .COMP_ID0(ID_VALS[4]), .COMP_ID1(ID_VALS[5]), .COMP_ID2(ID_VALS[6]), .COMP_ID3(ID_VALS[7])
  ) tbs_status_regs_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fmt_pipe_empty(fmt_pipe_empty), .fmt_stop_evt(fmt_stop_evt),
    .trig_in(trig_in), .ram_wr_ptr(ram_wr_ptr), .capture_enable_bit(capture_enable_bit),
    .formatter_halted_flag(formatter_halted_flag), .capture_active(capture_active),
    .fmt_ctrl(fmt_ctrl), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic pulse_trig();
    @(posedge clk);
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // idle after reset: capture disabled, so done is set
    rchk(OFF_STATUS, 32'h0000_000c);
    rchk(OFF_STATUS, 32'h0000_000c);
    rchk(OFF_RAM_DEPTH, RAM_DEPTH_DEFAULT);
    wr(OFF_RAM_DEPTH, 32'h0000_0000);
    rchk(OFF_RAM_DEPTH, RAM_DEPTH_DEFAULT);
    rchk(12'h100, RDATA_UNMAPPED);
    for (i = 0; i < 8; i++) begin
      rchk(OFF_PERIPH_ID0 + 12'(4 * i), ID_VALS[i]);
    end
    // start capture
    wr(OFF_CAPTURE_CTRL, 32'h0000_0001);
    chk({29'h0, capture_enable_bit, formatter_halted_flag, capture_active}, 32'h0000_0005);
    rchk(OFF_STATUS, 32'h0000_0008);
    // trigger ignored while observe is off
    pulse_trig();
    rchk(OFF_STATUS, 32'h0000_0008);
    wr(OFF_FMT_CTRL, 32'h0000_0001);
    pulse_trig();
    rchk(OFF_STATUS, 32'h0000_000a);
    // interrupt raise, mask and clear
    wr(OFF_IRQ_ENABLE, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(OFF_IRQ_CLEAR, 32'h0000_0002);
    rchk(OFF_IRQ_STATUS, 32'h0000_0000);
    wr(OFF_IRQ_ENABLE, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    // write pointer wrap
    @(posedge clk);
    ram_wr_ptr <= 10'h3fe;
    @(posedge clk);
    ram_wr_ptr <= 10'h3ff;
    rchk(OFF_STATUS, 32'h0000_000a);
    @(posedge clk);
    ram_wr_ptr <= 10'h000;
    repeat (3) @(posedge clk);
    rchk(OFF_STATUS, 32'h0000_000b);
    // pipeline not empty
    @(posedge clk);
    fmt_pipe_empty <= 1'b0;
    rchk(OFF_STATUS, 32'h0000_0003);
    @(posedge clk);
    fmt_pipe_empty <= 1'b1;
    // formatter stop ends the acquisition, flags stay sticky
    @(posedge clk);
    fmt_stop_evt <= 1'b1;
    @(posedge clk);
    fmt_stop_evt <= 1'b0;
    #1;
    chk({30'h0, formatter_halted_flag, capture_active}, 32'h0000_0002);
    rchk(OFF_FMT_STATUS, 32'h0000_0001);
    rchk(OFF_STATUS, 32'h0000_000f);
    rchk(OFF_IRQ_STATUS, 32'h0000_0005);
    // restart clears triggered and full
    wr(OFF_CAPTURE_CTRL, 32'h0000_0000);
    rchk(OFF_STATUS, 32'h0000_000f);
    wr(OFF_CAPTURE_CTRL, 32'h0000_0001);
    rchk(OFF_STATUS, 32'h0000_0008);
    // disabling capture alone completes the acquisition
    wr(OFF_CAPTURE_CTRL, 32'h0000_0000);
    rchk(OFF_STATUS, 32'h0000_000c);
    chk({31'h0, capture_active}, 32'h0000_0000);
    // stop on an observed trigger, then a direct stop request
    wr(OFF_CAPTURE_CTRL, 32'h0000_0001);
    wr(OFF_FMT_CTRL, 32'h0000_0003);
    chk({29'h0, fmt_ctrl}, 32'h0000_0003);
    pulse_trig();
    rchk(OFF_STATUS, 32'h0000_000e);
    chk({31'h0, formatter_halted_flag}, 32'h0000_0001);
    wr(OFF_CAPTURE_CTRL, 32'h0000_0000);
    wr(OFF_CAPTURE_CTRL, 32'h0000_0001);
    chk({31'h0, capture_active}, 32'h0000_0001);
    wr(OFF_FMT_CTRL, 32'h0000_0004);
    rchk(OFF_FMT_CTRL, 32'h0000_0000);
    rchk(OFF_FMT_STATUS, 32'h0000_0001);
    summarize();
  end
endmodule // tb_tbs_status_regs
`default_nettype wire
